// ---- logic/gsc_counter.sv ----
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// Functional notes
// - gate enabled and active: count on each counter clock edge
// - polarity 0 counts on low gate, 1 counts on high gate
// - gate inactive: count holds
// - source field: 00 pin, 01 8-bit overflow, 10 period match, 11 watchdog
// - 8-bit timer wrap FFh to 00h pulses the gate source
// - period timer resets to 00h after match, pulsing the gate source
// - gate on watchdog source forces watchdog oscillator on; counter still needs counter-on
// - gating-only watchdog gives no reset and no wake
// - prescaler bits choose watchdog timeout; do not change while measuring
// - counter wraps FFFFh to 0000h and sets sticky overflow flag
// - interrupt needs counter on, overflow, peripheral and global enables
// - counting in sleep only in asynchronous external-clock mode
// - in sleep that mode wakes the core on overflow
// - after wake, vector taken when global enable set
// - capture copies count into capture/compare pair on event
// - compare raises event when pair equals count
// - special trigger clears count without setting overflow flag
// - with special trigger the pair acts as period
// - counter write beats the special trigger clear
// - prescaler rate gives watchdog ratio 1:1 to 1:128
module gsc_counter
	import gsc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// pins and neighbours
	input  wire logic        gateInput,
	input  wire logic        extClkIn,
	input  wire logic        captureEvent,
	input  wire logic        sleepMode,
	// events to core
	output logic             coreIrq,
	output logic             wakeUp,
	output logic             cmpEvent,
	output logic             wdogTick
);
`include "gsc_defs.svh"

	typedef struct packed {
		logic        wrPend;
		logic [11:0] wrAddr;
		logic [31:0] rdata;
		logic [5:0]  ctrl;
		logic [3:0]  gateCfg;
		logic [15:0] count;
		logic [15:0] capcomp;
		logic [7:0]  t8Count;
		logic [7:0]  perCount;
		logic [7:0]  perLimit;
		logic [7:0]  option;
		logic [3:0]  irq;
		logic [2:0]  gateSync;
		logic        pinLevel;
		logic [2:0]  clkSync;
		logic        clkLast;
		logic [22:0] wdogCnt;
		logic        wdogPulse;
		logic        t8Pulse;
		logic        perPulse;
		logic        cmpOut;
		logic        irqOut;
		logic        wakeOut;
	} gsc_state_type;

	gsc_state_type stateReg;
	gsc_state_type stateNext;

	// watchdog terminal count for a given prescaler setting
	function automatic logic [22:0] wdogLimit(input logic [7:0] opt);
		logic [2:0] rate;
		rate = opt[2:0];
		if (opt[`GSC_OPT_ASSIGN]) begin
			wdogLimit = {7'h00, `GSC_WDOG_BASE} << rate;
		end else begin
			wdogLimit = {7'h00, `GSC_WDOG_BASE};
		end
	endfunction

	logic        writeCount;
	logic        srcRaw;
	logic        gateActive;
	logic        clkEdge;
	logic        asyncSleep;
	logic        wdogOn;
	logic        special;
	logic [15:0] cnt;
	logic [16:0] incSum;

	always_comb begin
		stateNext = stateReg;
		writeCount = stateReg.wrPend
			&& (stateReg.wrAddr == `GSC_ADDR_COUNT);
		// bus address phase
		if (hsel && hready && htrans[1]) begin
			stateNext.wrPend = hwrite;
			stateNext.wrAddr = haddr;
			case (haddr)
				`GSC_ADDR_CTRL:    stateNext.rdata = {26'h0, stateReg.ctrl};
				`GSC_ADDR_GATE:    stateNext.rdata = {28'h0, stateReg.gateCfg};
				`GSC_ADDR_COUNT:   stateNext.rdata = {16'h0, stateReg.count};
				`GSC_ADDR_CAPCOMP: stateNext.rdata = {16'h0, stateReg.capcomp};
				`GSC_ADDR_PERIOD:  stateNext.rdata = {16'h0, stateReg.perCount,
					stateReg.perLimit};
				`GSC_ADDR_OPTION:  stateNext.rdata = {24'h0, stateReg.option};
				`GSC_ADDR_IRQ:     stateNext.rdata = {28'h0, stateReg.irq};
				`GSC_ADDR_STATUS:  stateNext.rdata = {24'h0, stateReg.t8Count};
				default:           stateNext.rdata = 32'h0000_0000;
			endcase
		end else begin
			stateNext.wrPend = 1'b0;
		end
		// bus data phase writes
		if (stateReg.wrPend) begin
			case (stateReg.wrAddr)
				`GSC_ADDR_CTRL:    stateNext.ctrl = hwdata[5:0];
				`GSC_ADDR_GATE:    stateNext.gateCfg = hwdata[3:0];
				`GSC_ADDR_CAPCOMP: stateNext.capcomp = hwdata[15:0];
				`GSC_ADDR_PERIOD:  stateNext.perLimit = hwdata[7:0];
				`GSC_ADDR_OPTION:  stateNext.option = hwdata[7:0];
				`GSC_ADDR_IRQ:     stateNext.irq = hwdata[3:0];
				default: begin
				end
			endcase
		end

		// 8-bit timer free-runs; wrap gives a one-cycle pulse
		stateNext.t8Count = stateReg.t8Count + 8'h01;
		stateNext.t8Pulse = (stateReg.t8Count == 8'hFF);
		// period timer resets after matching its limit
		if (stateReg.perCount == stateReg.perLimit) begin
			stateNext.perCount = 8'h00;
			stateNext.perPulse = 1'b1;
		end else begin
			stateNext.perCount = stateReg.perCount + 8'h01;
			stateNext.perPulse = 1'b0;
		end

		// watchdog forced on by gating regardless of counter-on
		wdogOn = stateReg.gateCfg[`GSC_GATE_EN]
			&& (stateReg.gateCfg[3:2] == GSC_SRC_WDOG);
		stateNext.wdogPulse = 1'b0;
		if (wdogOn) begin
			if (stateReg.wdogCnt >= wdogLimit(stateReg.option)) begin
				stateNext.wdogCnt = 23'h00_0000;
				stateNext.wdogPulse = 1'b1;
			end else begin
				stateNext.wdogCnt = stateReg.wdogCnt + 23'h00_0001;
			end
		end else begin
			stateNext.wdogCnt = 23'h00_0000;
		end

		// pin level changes once the second and third stages agree
		stateNext.gateSync = {stateReg.gateSync[1:0], gateInput};
		if (stateReg.gateSync[1] == stateReg.gateSync[2]) begin
			stateNext.pinLevel = stateReg.gateSync[2];
		end
		case (gsc_src_type'(stateReg.gateCfg[3:2]))
			GSC_SRC_PIN:  srcRaw = stateReg.pinLevel;
			GSC_SRC_T8:   srcRaw = stateReg.t8Pulse;
			GSC_SRC_PER:  srcRaw = stateReg.perPulse;
			GSC_SRC_WDOG: srcRaw = stateReg.wdogPulse;
			default:      srcRaw = 1'b0;
		endcase
		// same-clock pulses bypass the synchroniser so one-cycle pulses count
		gateActive = !stateReg.gateCfg[`GSC_GATE_EN]
			|| (srcRaw ~^ stateReg.gateCfg[`GSC_GATE_POL]);

		// counter clock edge: system clock or synchronised external edge
		stateNext.clkSync = {stateReg.clkSync[1:0], extClkIn};
		stateNext.clkLast = stateReg.clkSync[2];
		if (stateReg.ctrl[`GSC_CTRL_EXTCLK]) begin
			clkEdge = stateReg.clkSync[1] && stateReg.clkSync[2]
				&& !stateReg.clkLast;
		end else begin
			clkEdge = 1'b1;
		end
		asyncSleep = stateReg.ctrl[`GSC_CTRL_EXTCLK]
			&& stateReg.ctrl[`GSC_CTRL_SYNCDIS];
		if (sleepMode && !asyncSleep) begin
			clkEdge = 1'b0;
		end

		// main counter
		cnt = stateReg.count;
		incSum = {1'b0, cnt} + 17'h0_0001;
		special = stateReg.ctrl[`GSC_CTRL_CMPEN]
			&& stateReg.ctrl[`GSC_CTRL_SPECIAL]
			&& (stateReg.count == stateReg.capcomp);
		if (writeCount) begin
			stateNext.count = hwdata[15:0];
		end else if (special) begin
			stateNext.count = 16'h0000;
		end else if (stateReg.ctrl[`GSC_CTRL_ON] && clkEdge && gateActive) begin
			stateNext.count = incSum[15:0];
			if (incSum[16]) begin
				stateNext.irq[`GSC_IRQ_FLAG] = 1'b1;
			end
		end

		// capture and compare
		if (stateReg.ctrl[`GSC_CTRL_CAPEN] && captureEvent) begin
			stateNext.capcomp = stateReg.count;
		end
		stateNext.cmpOut = stateReg.ctrl[`GSC_CTRL_CMPEN]
			&& (stateReg.count == stateReg.capcomp);

		// interrupt and wake; watchdog never wakes
		stateNext.irqOut = stateReg.ctrl[`GSC_CTRL_ON]
			&& stateReg.irq[`GSC_IRQ_FLAG] && stateReg.irq[`GSC_IRQ_IE]
			&& stateReg.irq[`GSC_IRQ_PERIPH]
			&& stateReg.irq[`GSC_IRQ_GLOBAL];
		stateNext.wakeOut = sleepMode && asyncSleep
			&& stateReg.ctrl[`GSC_CTRL_ON]
			&& stateReg.irq[`GSC_IRQ_FLAG] && stateReg.irq[`GSC_IRQ_IE]
			&& stateReg.irq[`GSC_IRQ_PERIPH];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stateReg <= '0;
			stateReg.option <= `GSC_OPT_RESET;
		end else begin
			stateReg <= stateNext;
		end
	end

	always_comb begin
		hrdata = stateReg.rdata;
		hreadyout = 1'b1;
		hresp = 1'b0;
		coreIrq = stateReg.irqOut;
		wakeUp = stateReg.wakeOut;
		cmpEvent = stateReg.cmpOut;
		wdogTick = stateReg.wdogPulse;
	end

	property p_wrap_sets_flag;
		@(posedge clk) disable iff (!nrst)
		(stateReg.count == 16'hFFFF && stateNext.count == 16'h0000
			&& !special && !writeCount)
		|=> stateReg.irq[`GSC_IRQ_FLAG];
	endproperty
	a_wrap_sets_flag: assert property (p_wrap_sets_flag)
		else $error("wrap did not set flag");

	property p_hold_inactive;
		@(posedge clk) disable iff (!nrst)
		(stateReg.gateCfg[`GSC_GATE_EN] && !gateActive
			&& !writeCount && !special)
		|=> $stable(stateReg.count);
	endproperty
	a_hold_inactive: assert property (p_hold_inactive)
		else $error("count moved while gate inactive");

	property p_special_clear;
		@(posedge clk) disable iff (!nrst)
		(special && !writeCount) |=> (stateReg.count == 16'h0000);
	endproperty
	a_special_clear: assert property (p_special_clear)
		else $error("special trigger did not clear");

	property p_write_wins;
		@(posedge clk) disable iff (!nrst)
		writeCount |=> (stateReg.count == $past(hwdata[15:0]));
	endproperty
	a_write_wins: assert property (p_write_wins)
		else $error("counter write lost");

	property p_irq_gated;
		@(posedge clk) disable iff (!nrst)
		coreIrq |-> $past(stateReg.irq[`GSC_IRQ_GLOBAL])
			&& $past(stateReg.ctrl[`GSC_CTRL_ON]);
	endproperty
	a_irq_gated: assert property (p_irq_gated)
		else $error("interrupt without enables");

	property p_t8_pulse;
		@(posedge clk) disable iff (!nrst)
		(stateReg.t8Count == 8'hFF) |=> stateReg.t8Pulse;
	endproperty
	a_t8_pulse: assert property (p_t8_pulse)
		else $error("8-bit wrap pulse missing");

	property p_per_reset;
		@(posedge clk) disable iff (!nrst)
		(stateReg.perCount == stateReg.perLimit && !stateReg.wrPend)
		|=> (stateReg.perCount == 8'h00) && stateReg.perPulse;
	endproperty
	a_per_reset: assert property (p_per_reset)
		else $error("period timer did not reset");

	property p_wdog_off;
		@(posedge clk) disable iff (!nrst)
		!wdogOn |=> !stateReg.wdogPulse;
	endproperty
	a_wdog_off: assert property (p_wdog_off)
		else $error("watchdog ran while not selected");

	property p_capture;
		@(posedge clk) disable iff (!nrst)
		(stateReg.ctrl[`GSC_CTRL_CAPEN] && captureEvent && !stateReg.wrPend)
		|=> (stateReg.capcomp == $past(stateReg.count));
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture value wrong");

	property p_no_wake_awake;
		@(posedge clk) disable iff (!nrst)
		!sleepMode |=> !wakeUp;
	endproperty
	a_no_wake_awake: assert property (p_no_wake_awake)
		else $error("wake while not sleeping");

	property p_count_step;
		@(posedge clk) disable iff (!nrst)
		(stateReg.ctrl[`GSC_CTRL_ON] && clkEdge && gateActive
			&& !writeCount && !special)
		|=> (stateReg.count == $past(stateReg.count) + 16'h0001);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("count did not step");

	property p_special_no_flag;
		@(posedge clk) disable iff (!nrst)
		(special && !stateReg.irq[`GSC_IRQ_FLAG]
			&& !(stateReg.wrPend && stateReg.wrAddr == `GSC_ADDR_IRQ))
		|=> !stateReg.irq[`GSC_IRQ_FLAG];
	endproperty
	a_special_no_flag: assert property (p_special_no_flag)
		else $error("special trigger set the flag");

	property p_cmp_event;
		@(posedge clk) disable iff (!nrst)
		(stateReg.ctrl[`GSC_CTRL_CMPEN]
			&& stateReg.count == stateReg.capcomp)
		|=> cmpEvent;
	endproperty
	a_cmp_event: assert property (p_cmp_event)
		else $error("compare event missing");

	property p_sleep_freeze;
		@(posedge clk) disable iff (!nrst)
		(sleepMode && !asyncSleep && !writeCount && !special)
		|=> $stable(stateReg.count);
	endproperty
	a_sleep_freeze: assert property (p_sleep_freeze)
		else $error("count moved in sleep");

	property p_wdog_period;
		@(posedge clk) disable iff (!nrst)
		(wdogOn && stateReg.wdogCnt == wdogLimit(stateReg.option))
		|=> wdogTick;
	endproperty
	a_wdog_period: assert property (p_wdog_period)
		else $error("watchdog tick missing at terminal count");

	property p_wdog_no_wake;
		@(posedge clk) disable iff (!nrst)
		!asyncSleep |=> !wakeUp;
	endproperty
	a_wdog_no_wake: assert property (p_wdog_no_wake)
		else $error("wake outside asynchronous counting");
endmodule

// ---- shared/gsc_defs.svh ----
`ifndef GSC_DEFS_SVH
`define GSC_DEFS_SVH
// register byte addresses
`define GSC_ADDR_CTRL     12'h000
`define GSC_ADDR_GATE     12'h004
`define GSC_ADDR_COUNT    12'h008
`define GSC_ADDR_CAPCOMP  12'h00C
`define GSC_ADDR_PERIOD   12'h010
`define GSC_ADDR_OPTION   12'h014
`define GSC_ADDR_IRQ      12'h018
`define GSC_ADDR_STATUS   12'h01C
// ctrl fields
`define GSC_CTRL_ON       0
`define GSC_CTRL_SYNCDIS  1
`define GSC_CTRL_EXTCLK   2
`define GSC_CTRL_CMPEN    3
`define GSC_CTRL_SPECIAL  4
`define GSC_CTRL_CAPEN    5
// gate fields
`define GSC_GATE_EN       0
`define GSC_GATE_POL      1
`define GSC_GATE_SS_LO    2
// irq fields
`define GSC_IRQ_FLAG      0
`define GSC_IRQ_IE        1
`define GSC_IRQ_PERIPH    2
`define GSC_IRQ_GLOBAL    3
// option fields
`define GSC_OPT_ASSIGN    3
`define GSC_OPT_RESET     8'hFF
`define GSC_WDOG_BASE     16'h00FF
`endif

// ---- shared/gsc_pkg.sv ----
package gsc_pkg;
	typedef enum logic [1:0] {
		GSC_SRC_PIN   = 2'b00,
		GSC_SRC_T8    = 2'b01,
		GSC_SRC_PER   = 2'b10,
		GSC_SRC_WDOG  = 2'b11
	} gsc_src_type;
	typedef enum logic [1:0] {
		GSC_BUS_IDLE = 2'b01,
		GSC_BUS_DATA = 2'b10
	} gsc_bus_type;
	typedef struct packed {
		logic [31:0] rdata;
		logic        ready;
	} gsc_ahbout_type;
	typedef struct packed {
		logic        wdogTick;
		logic        wakeUp;
		logic        coreIrq;
		logic        cmpEvent;
	} gsc_evout_type;
endpackage

// ---- sim/gated_sixteen_bit_counter_bench.sv ----
`timescale 1ns/1ps
`include "gsc_defs.svh"
module gated_sixteen_bit_counter_bench;
	logic        clk;
	logic        nrst;
	logic        hsel;
	logic        hwrite;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        gateLevel;
	logic        capReq;
	logic        clkRun;
	logic        gateInput;
	logic        extClkIn;
	logic        captureEvent;
	logic        sleepMode;
	logic        coreIrq;
	logic        wakeUp;
	logic        cmpEvent;
	logic        wdogTick;
	logic [31:0] rdq;
	logic [31:0] a;
	logic [31:0] b;
	int          n_mismatch = 0;
	int          compares = 0;
	int          nTick = 0;
	int          nWake = 0;
	int          nCmp = 0;
	int          k;

	gsc_counter DUT (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(), .gateInput(gateInput), .extClkIn(extClkIn),
		.captureEvent(captureEvent), .sleepMode(sleepMode),
		.coreIrq(coreIrq), .wakeUp(wakeUp), .cmpEvent(cmpEvent),
		.wdogTick(wdogTick));
	gsc_far_model far (.clk(clk), .gateLevel(gateLevel), .capReq(capReq),
		.clkRun(clkRun),
		.gateInput(gateInput), .extClkIn(extClkIn),
		.captureEvent(captureEvent));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		rdq <= hrdata;
		nTick <= nTick + int'(wdogTick);
		nWake <= nWake + int'(wakeUp);
		nCmp <= nCmp + int'(cmpEvent);
	end

	task results;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task waitc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one single transfer; data taken at the edge ending the data phase
	task bus(input logic w, input logic [11:0] ad, input logic [31:0] d,
		output logic [31:0] q);
		int t;
		t = 0;
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= ad;
		hwrite <= w;
		htrans <= 2'b10;
		do begin
			@(posedge clk);
			t++;
		end while (hreadyout !== 1'b1 && t < 50);
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(posedge clk);
			t++;
		end while (hreadyout !== 1'b1 && t < 100);
		@(negedge clk);
		q = rdq;
		if (t >= 100) n_mismatch++;
	endtask
	task wr(input logic [11:0] ad, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, ad, d, q);
	endtask
	task rd(input logic [11:0] ad, output logic [31:0] q);
		bus(1'b0, ad, 32'h0000_0000, q);
	endtask
	task setIn(input logic g, input logic s);
		@(posedge clk);
		gateLevel <= g;
		sleepMode <= s;
	endtask
	task holdChk;
		waitc(10);
		rd(`GSC_ADDR_COUNT, a);
		waitc(20);
		rd(`GSC_ADDR_COUNT, b);
		chk(b, a);
	endtask

	task t_reset;
		rd(`GSC_ADDR_OPTION, a);
		chk(a, 32'h0000_00FF);
		rd(12'h020, a);
		chk(a, 32'h0000_0000);
	endtask
	task t_gate;
		wr(`GSC_ADDR_GATE, 32'h0000_0003);
		setIn(1'b0, 1'b0);
		wr(`GSC_ADDR_COUNT, 32'h0000_0000);
		wr(`GSC_ADDR_CTRL, 32'h0000_0001);
		holdChk;
		setIn(1'b1, 1'b0);
		waitc(10);
		rd(`GSC_ADDR_COUNT, a);
		chk(32'(a > b), 32'h0000_0001);
		wr(`GSC_ADDR_GATE, 32'h0000_0001);
		holdChk;
		setIn(1'b0, 1'b0);
		waitc(10);
		rd(`GSC_ADDR_COUNT, a);
		chk(32'(a > b), 32'h0000_0001);
		wr(`GSC_ADDR_GATE, 32'h0000_0000);
		setIn(1'b1, 1'b1);
		holdChk;
		setIn(1'b0, 1'b0);
	endtask
	task t_irq;
		wr(`GSC_ADDR_CTRL, 32'h0000_0000);
		wr(`GSC_ADDR_IRQ, 32'h0000_0000);
		wr(`GSC_ADDR_COUNT, 32'h0000_FFF0);
		wr(`GSC_ADDR_CTRL, 32'h0000_0001);
		waitc(40);
		wr(`GSC_ADDR_CTRL, 32'h0000_0000);
		rd(`GSC_ADDR_COUNT, a);
		chk(32'(a < 32'h40), 32'h0000_0001);
		rd(`GSC_ADDR_IRQ, a);
		chk(a & 32'h1, 32'h0000_0001);
		wr(`GSC_ADDR_IRQ, 32'h0000_000F);
		waitc(3);
		chk(32'(coreIrq), 32'h0000_0000);
		wr(`GSC_ADDR_CTRL, 32'h0000_0001);
		waitc(3);
		chk(32'(coreIrq), 32'h0000_0001);
		wr(`GSC_ADDR_IRQ, 32'h0000_0007);
		waitc(3);
		chk(32'(coreIrq), 32'h0000_0000);
		rd(`GSC_ADDR_IRQ, a);
		chk(a & 32'h1, 32'h0000_0001);
		wr(`GSC_ADDR_IRQ, 32'h0000_0000);
		wr(`GSC_ADDR_CTRL, 32'h0000_0020);
		wr(`GSC_ADDR_COUNT, 32'h0000_1234);
		@(posedge clk);
		capReq <= 1'b1;
		@(posedge clk);
		capReq <= 1'b0;
		waitc(4);
		rd(`GSC_ADDR_CAPCOMP, a);
		chk(a, 32'h0000_1234);
	endtask
	task t_special;
		wr(`GSC_ADDR_CAPCOMP, 32'h0000_0010);
		wr(`GSC_ADDR_COUNT, 32'h0000_0000);
		k = nCmp;
		wr(`GSC_ADDR_CTRL, 32'h0000_0019);
		waitc(100);
		wr(`GSC_ADDR_CTRL, 32'h0000_0000);
		rd(`GSC_ADDR_COUNT, a);
		chk(32'(a <= 32'h10), 32'h0000_0001);
		chk(32'(nCmp > k), 32'h0000_0001);
		rd(`GSC_ADDR_IRQ, a);
		chk(a & 32'h1, 32'h0000_0000);
	endtask
	task t_sources;
		wr(`GSC_ADDR_OPTION, 32'h0000_0008);
		wr(`GSC_ADDR_PERIOD, 32'h0000_000F);
		wr(`GSC_ADDR_CTRL, 32'h0000_0001);
		for (int s = 1; s < 4; s++) begin
			wr(`GSC_ADDR_GATE, 32'((s << 2) | 3));
			wr(`GSC_ADDR_COUNT, 32'h0000_0000);
			waitc(600);
			rd(`GSC_ADDR_COUNT, a);
			chk(32'(a != 0 && a < 200), 32'h0000_0001);
		end
		wr(`GSC_ADDR_CTRL, 32'h0000_0000);
		setIn(1'b0, 1'b1);
		k = nTick;
		b = 32'(nWake);
		waitc(600);
		chk(32'(nTick - k >= 2), 32'h0000_0001);
		chk(32'(nWake), b);
		wr(`GSC_ADDR_OPTION, 32'h0000_0009);
		k = nTick;
		waitc(1100);
		chk(32'(nTick - k inside {2, 3}), 32'h0000_0001);
		setIn(1'b0, 1'b0);
	endtask
	task t_sleep;
		wr(`GSC_ADDR_GATE, 32'h0000_0000);
		wr(`GSC_ADDR_IRQ, 32'h0000_0000);
		wr(`GSC_ADDR_COUNT, 32'h0000_FFFE);
		wr(`GSC_ADDR_IRQ, 32'h0000_0006);
		wr(`GSC_ADDR_CTRL, 32'h0000_0007);
		setIn(1'b0, 1'b1);
		b = 32'(nWake);
		clkRun <= 1'b1;
		waitc(60);
		clkRun <= 1'b0;
		chk(32'(nWake > b), 32'h0000_0001);
		rd(`GSC_ADDR_COUNT, a);
		chk(32'(a > 0 && a < 32'h10), 32'h0000_0001);
		setIn(1'b0, 1'b0);
		wr(`GSC_ADDR_CTRL, 32'h0000_0000);
	endtask

	initial begin
		nrst = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 12'h000;
		htrans = 2'b00;
		hwdata = 32'h0000_0000;
		gateLevel = 1'b0;
		capReq = 1'b0;
		clkRun = 1'b0;
		sleepMode = 1'b0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		t_reset;
		t_gate;
		t_irq;
		t_special;
		t_sources;
		t_sleep;
		results;
	end
	initial begin
		#200_000;
		n_mismatch++;
		results;
	end
endmodule

// ---- sim/gsc_far_model.sv ----
`timescale 1ns/1ps
module gsc_far_model (
	// clock
	input  wire logic clk,
	// commands from the bench
	input  wire logic gateLevel,
	input  wire logic capReq,
	input  wire logic clkRun,
	// pins toward the counter
	output logic      gateInput,
	output logic      extClkIn,
	output logic      captureEvent
);
	logic [2:0] extDiv;
	// external clock runs only while the bench asks, period of 8 clocks
	assign extClkIn = extDiv[2];
	initial begin
		gateInput = 1'b0;
		captureEvent = 1'b0;
		extDiv = 3'h0;
	end
	always @(posedge clk) begin
		gateInput <= gateLevel;
		captureEvent <= capReq;
		if (clkRun)
			extDiv <= extDiv + 3'h1;
	end
endmodule
